// *** lgh_host_port.sv ***
// host-side chip-select controller driving the generic 16-bit port of an LCD controller
// assumes software drives it over classic Wishbone; device pins come from another clock tree
`timescale 1ns/1ps
`include "lgh_consts.svh"
module lgh_host_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             host_clock_o,
  output logic             dev_reset_n_o,
  output logic             endian_strap_o,
  output logic             stall_polarity_strap_o,
  output logic             bus_start_n_o,
  output logic      [16:0] host_address_bus_o,
  output logic             mem_sel_o,
  output logic             chip_select_n_o,
  output logic             low_byte_write_n_o,
  output logic             high_byte_write_n_o,
  output logic             low_byte_read_n_o,
  output logic             high_byte_read_n_o,
  output logic      [15:0] host_data_bus_o,
  output logic             host_data_bus_oe_o,
  input  wire logic [15:0] host_data_bus_i,
  input  wire logic        transfer_acknowledge_i,
  output logic             burst_inhibit_o
);
  lgh_pkg::lgh_state_type state;
  logic [15:0] ctrl;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic [1:0]  lanes;
  logic [15:0] rdata;
  logic        done;
  logic        first;
  logic [1:0]  phase;
  logic        wb_hit;
  logic        wb_wr;
  logic        start_req;
  logic        tmr_load;
  logic [7:0]  tmr_count;
  logic        tmr_expired;
  logic        ack_s;
  logic [15:0] data_s;
  logic        is_write;
  logic        big;
  logic [1:0]  lanes_eff;
  logic        in_access;

  // byte swap used for data in both directions; lanes_eff swaps the lane enables on its own
  function automatic logic [15:0] swap16(input logic [15:0] d, input logic en);
    swap16 = en ? {d[7:0], d[15:8]} : d;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // setup length: one cycle of address, then assert delay, relaxed and hold extras
  function automatic logic [7:0] setup_len(input logic [15:0] c, input logic fst);
    logic [7:0] select_assert_delay;
    select_assert_delay = (c[`LGH_CTRL_ACS_LO+1]) ? 8'(`LGH_HALF_CYC) : (c[`LGH_CTRL_ACS_LO] ? 8'(`LGH_QTR_CYC) : 8'h00);
    setup_len = 8'h01 + select_assert_delay
              + (c[`LGH_CTRL_RELAX] ? 8'(`LGH_BUS_CYC) : 8'h00)
              + ((c[`LGH_CTRL_EHOLD] && fst) ? 8'(`LGH_BUS_CYC) : 8'h00);
  endfunction

  // early negation shortens writes only; a two-cycle read would end before synced data lands
  function automatic logic [7:0] access_len(input logic [15:0] c);
    logic [7:0] ws;
    ws = {4'h0, c[`LGH_CTRL_WS_LO+3:`LGH_CTRL_WS_LO]} + 8'h01;
    access_len = 8'(ws * `LGH_BUS_CYC) - ((c[`LGH_CTRL_ENEG] && c[`LGH_CTRL_WRITE]) ? 8'(`LGH_HALF_CYC) : 8'h00);
  endfunction

  assign is_write  = ctrl[`LGH_CTRL_WRITE];
  assign big       = ctrl[`LGH_CTRL_BIG];
  assign lanes_eff = big ? {lanes[0], lanes[1]} : lanes;
  assign in_access = (state == lgh_pkg::LGH_ACCESS);
  assign wb_hit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_hit && wb_we_i;
  assign start_req = wb_wr && (wb_adr_i == `LGH_OFS_CTRL) && wb_sel_i[0]
                   && wb_dat_i[`LGH_CTRL_START] && (state == lgh_pkg::LGH_IDLE);

  lgh_sync2 #(.WIDTH(17)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({transfer_acknowledge_i, host_data_bus_i}),
    .q_o   ({ack_s, data_s})
  );

  lgh_timer #(.WIDTH(8)) u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .expired_o (tmr_expired)
  );

  // device clock is a divided copy of ours; its pins are still synchronised as a second domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign host_clock_o = ~phase[1];

  // wishbone slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        if (wb_adr_i == `LGH_OFS_CTRL) begin
          wb_dat_o <= {16'h0000, ctrl};
        end else if (wb_adr_i == `LGH_OFS_ADDR) begin
          wb_dat_o <= {15'h0000, addr};
        end else if (wb_adr_i == `LGH_OFS_WDATA) begin
          wb_dat_o <= {14'h0000, lanes, wdata};
        end else if (wb_adr_i == `LGH_OFS_RDATA) begin
          wb_dat_o <= {16'h0000, rdata};
        end else if (wb_adr_i == `LGH_OFS_STATUS) begin
          wb_dat_o <= {29'h0000_0000, first, done, (state != lgh_pkg::LGH_IDLE)};
        end
      end
    end
  end

  // configuration is frozen while a cycle runs so timing cannot change mid-access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl  <= `LGH_CTRL_RESET;
      addr  <= 17'h0_0000;
      wdata <= 16'h0000;
      lanes <= 2'h3;
    end else if (wb_wr && state == lgh_pkg::LGH_IDLE) begin
      if (wb_adr_i == `LGH_OFS_CTRL) begin
        ctrl <= merge16(ctrl, wb_dat_i, wb_sel_i) & 16'hFFFE;
      end else if (wb_adr_i == `LGH_OFS_ADDR) begin
        addr <= {wb_sel_i[2] ? wb_dat_i[16] : addr[16], merge16(addr[15:0], wb_dat_i, wb_sel_i)};
      end else if (wb_adr_i == `LGH_OFS_WDATA) begin
        wdata <= merge16(wdata, wb_dat_i, wb_sel_i);
        if (wb_sel_i[2]) begin
          lanes <= wb_dat_i[`LGH_WDATA_LANE_LO+1:`LGH_WDATA_LANE_LO];
        end
      end
    end
  end

  // extended hold applies to the first access after reset only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first <= 1'b1;
    end else if (state == lgh_pkg::LGH_SETUP && tmr_expired) begin
      first <= 1'b0;
    end
  end

  // done: a finishing cycle wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done <= 1'b0;
    end else if (state == lgh_pkg::LGH_RELEASE && !(ctrl[`LGH_CTRL_USEACK] && ack_s)) begin
      done <= 1'b1;
    end else if (wb_wr && wb_adr_i == `LGH_OFS_STATUS && wb_sel_i[0] && wb_dat_i[`LGH_STAT_DONE]) begin
      done <= 1'b0;
    end else if (start_req) begin
      done <= 1'b0;
    end
  end

  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = 8'h00;
    if (start_req) begin
      tmr_load  = 1'b1;
      tmr_count = setup_len(wb_dat_i[15:0], first) - 8'h01;
    end else if (state == lgh_pkg::LGH_SETUP && tmr_expired) begin
      // counted wait states, shortened by early negation on writes only
      tmr_load  = 1'b1;
      tmr_count = access_len(ctrl) - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= lgh_pkg::LGH_IDLE;
      rdata <= 16'h0000;
    end else begin
      case (state)
        lgh_pkg::LGH_IDLE: begin
          if (start_req) begin
            state <= lgh_pkg::LGH_SETUP;
          end
        end
        lgh_pkg::LGH_SETUP: begin
          if (tmr_expired) begin
            state <= lgh_pkg::LGH_ACCESS;
          end
        end
        lgh_pkg::LGH_ACCESS: begin
          // end on acknowledge or on the wait-state count
          if (ctrl[`LGH_CTRL_USEACK] ? ack_s : tmr_expired) begin
            state <= lgh_pkg::LGH_RELEASE;
            if (!is_write) begin
              rdata <= swap16(data_s, big);
            end
          end
        end
        lgh_pkg::LGH_RELEASE: begin
          // wait for acknowledge to drop before another cycle
          if (!(ctrl[`LGH_CTRL_USEACK] && ack_s)) begin
            state <= lgh_pkg::LGH_IDLE;
          end
        end
        default: begin
          state <= lgh_pkg::LGH_IDLE;
        end
      endcase
    end
  end

  // chip select only during the strobe phase of an access
  assign chip_select_n_o     = ~in_access;
  assign low_byte_write_n_o  = ~(in_access && is_write && lanes_eff[0]);
  assign high_byte_write_n_o = ~(in_access && is_write && lanes_eff[1]);
  // one strobe drives both read enables
  assign low_byte_read_n_o   = ~(in_access && !is_write);
  assign high_byte_read_n_o  = low_byte_read_n_o;
  assign bus_start_n_o       = 1'b1;
  // burst inhibit while the region is addressed
  assign burst_inhibit_o     = ctrl[`LGH_CTRL_BINH] && (state != lgh_pkg::LGH_IDLE);
  assign stall_polarity_strap_o = 1'b1;
  assign endian_strap_o      = big;
  assign dev_reset_n_o       = ~ctrl[`LGH_CTRL_DEVRST];
  assign host_address_bus_o  = addr;
  assign mem_sel_o           = ctrl[`LGH_CTRL_MEM];
  assign host_data_bus_o     = swap16(wdata, big);
  // data stays driven through the release state past the strobe for hold
  assign host_data_bus_oe_o  = is_write && (in_access || state == lgh_pkg::LGH_RELEASE);

  // helper counters for phase-length checks
  logic [7:0] setup_cnt;
  logic [7:0] acc_cnt;
  logic [7:0] setup_exp;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_cnt <= 8'h00;
      acc_cnt   <= 8'h00;
      setup_exp <= 8'h00;
    end else begin
      setup_cnt <= (state == lgh_pkg::LGH_SETUP) ? setup_cnt + 8'h01 : 8'h00;
      acc_cnt   <= in_access ? acc_cnt + 8'h01 : 8'h00;
      if (start_req) begin
        setup_exp <= setup_len(wb_dat_i[15:0], first);
      end
    end
  end

  cs_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !chip_select_n_o |-> (state == lgh_pkg::LGH_ACCESS) && $past(state) != lgh_pkg::LGH_IDLE)
    else $error("chip select outside access");
  rd_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_byte_read_n_o == high_byte_read_n_o) && (low_byte_read_n_o || (!chip_select_n_o && !is_write)))
    else $error("read enables split");
  we_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_access && is_write && lanes_eff[0] |-> !low_byte_write_n_o && !low_byte_read_n_o == 1'b0)
    else $error("low write enable missing");
  we_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(in_access) && is_write && lanes_eff[1] |-> !high_byte_write_n_o [*2])
    else $error("high write enable missing");
  setup_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(in_access) |-> setup_cnt == setup_exp)
    else $error("setup length wrong");
  wait_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(in_access) && !ctrl[`LGH_CTRL_USEACK] |-> $past(acc_cnt) == access_len(ctrl) - 8'h01)
    else $error("wait state count wrong");
  ack_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == lgh_pkg::LGH_RELEASE && ctrl[`LGH_CTRL_USEACK] && ack_s |=> state != lgh_pkg::LGH_IDLE)
    else $error("new cycle before acknowledge drop");
  bus_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_start_n_o && stall_polarity_strap_o)
    else $error("bus start not high");
  burst_inh_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_access && ctrl[`LGH_CTRL_BINH] |-> burst_inhibit_o)
    else $error("burst inhibit missing");
  setup_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == lgh_pkg::LGH_SETUP) |-> ##[1:12] in_access)
    else $error("setup overran");
  addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state != lgh_pkg::LGH_IDLE && $past(state) != lgh_pkg::LGH_IDLE
    |-> $stable(host_address_bus_o) && $stable(mem_sel_o))
    else $error("address moved during cycle");
  rd_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !low_byte_read_n_o |-> !host_data_bus_oe_o)
    else $error("bus driven during read");
  done_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == lgh_pkg::LGH_RELEASE && !(ctrl[`LGH_CTRL_USEACK] && ack_s) |=> done && state == lgh_pkg::LGH_IDLE)
    else $error("cycle end not reported");

  read_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(in_access) && !is_write);
  write_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(in_access) && is_write);
  ack_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) in_access && ack_s && ctrl[`LGH_CTRL_USEACK]);
  eneg_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(in_access) && is_write && ctrl[`LGH_CTRL_ENEG]);
endmodule // lgh_host_port

// *** lgh_consts.svh ***
// constants for the generic host port controller: register map, fields, timing
// assumes a 200 MHz system clock and a device bus clock of one quarter of it
`ifndef LGH_CONSTS_SVH
`define LGH_CONSTS_SVH

`define LGH_CLK_NS        5
`define LGH_BUS_CLK_NS    20
`define LGH_QTR_CYC       (`LGH_BUS_CLK_NS / 4 / `LGH_CLK_NS)
`define LGH_BUS_CYC       (`LGH_BUS_CLK_NS / `LGH_CLK_NS)
`define LGH_HALF_CYC      (`LGH_BUS_CLK_NS / 2 / `LGH_CLK_NS)

`define LGH_OFS_CTRL      8'h00
`define LGH_OFS_ADDR      8'h04
`define LGH_OFS_WDATA     8'h08
`define LGH_OFS_RDATA     8'h0C
`define LGH_OFS_STATUS    8'h10

`define LGH_CTRL_START    0
`define LGH_CTRL_WRITE    1
`define LGH_CTRL_MEM      2
`define LGH_CTRL_BIG      3
`define LGH_CTRL_RELAX    4
`define LGH_CTRL_EHOLD    5
`define LGH_CTRL_ENEG     6
`define LGH_CTRL_USEACK   7
`define LGH_CTRL_WS_LO    8
`define LGH_CTRL_ACS_LO   12
`define LGH_CTRL_BINH     14
`define LGH_CTRL_DEVRST   15
`define LGH_CTRL_RESET    16'h8000

`define LGH_STAT_BUSY     0
`define LGH_STAT_DONE     1
`define LGH_STAT_FIRST    2
`define LGH_WDATA_LANE_LO 16

`endif

// *** lgh_pkg.sv ***
// types for the generic host port controller
package lgh_pkg;
  typedef enum logic [3:0] {
    LGH_IDLE    = 4'h1,
    LGH_SETUP   = 4'h2,
    LGH_ACCESS  = 4'h4,
    LGH_RELEASE = 4'h8
  } lgh_state_type;
endpackage

// *** lgh_sync2.sv ***
// two-flop synchroniser for pins coming from the device
// assumes the data bus is stable whenever the acknowledge is seen, so both stay aligned
`timescale 1ns/1ps
module lgh_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // lgh_sync2

// *** lgh_timer.sv ***
// down counter for cycle-accurate phase lengths; load n-1 for a phase of n cycles
// assumes load_i is a single-cycle pulse from the sequencer
`timescale 1ns/1ps
module lgh_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  expired_o
);
  logic [WIDTH-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (load_i) begin
      cnt <= count_i;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign expired_o = (cnt == '0);
endmodule // lgh_timer

// *** lgh_dev_model.sv ***
// behavioural model of the LCD controller's generic 16-bit host port
// assumes pins straight from lgh_host_port, and the data wire resolved by the bench
`timescale 1ns/1ps
module lgh_dev_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        endian_i,
  input  wire logic        polarity_i,
  input  wire logic [16:0] addr_i,
  input  wire logic        mem_sel_i,
  input  wire logic        cs_n_i,
  input  wire logic        we_lo_n_i,
  input  wire logic        we_hi_n_i,
  input  wire logic        rd_lo_n_i,
  input  wire logic [15:0] bus_i,
  input  wire logic [3:0]  stall_i,
  output logic      [15:0] dat_o,
  output logic             oe_o,
  output logic             ack_o
);
  logic [15:0] buf_mem [0:255];
  logic [15:0] reg_mem [0:63];
  logic [16:0] last_addr;
  logic        last_mem, big, pol, ready, acked;
  logic [3:0]  cnt;
  logic [15:0] native;
  initial for (int i = 0; i < 256; i++) begin
    buf_mem[i] = 16'h0000;
    reg_mem[i % 64] = 16'h0000;
  end
  always @(posedge reset_n_i) begin
    big <= endian_i;
    pol <= polarity_i;
  end
  always @(negedge cs_n_i) begin
    last_addr <= addr_i;
    last_mem <= mem_sel_i;
  end
  task automatic store(input logic hi);
    logic [7:0] b;
    int nb;
    b = hi ? bus_i[15:8] : bus_i[7:0];
    nb = (hi ^ big) ? 8 : 0;
    if (last_mem) buf_mem[last_addr[7:0]][nb +: 8] = b;
    else reg_mem[last_addr[5:0]][nb +: 8] = b;
  endtask
  // the write lands when its strobe ends, as on an asynchronous port
  always @(posedge we_lo_n_i) if (reset_n_i === 1'h1) store(1'h0);
  always @(posedge we_hi_n_i) if (reset_n_i === 1'h1) store(1'h1);
  assign native = mem_sel_i ? buf_mem[addr_i[7:0]] : reg_mem[addr_i[5:0]];
  assign oe_o = reset_n_i && !cs_n_i && !rd_lo_n_i;
  assign dat_o = big ? {native[7:0], native[15:8]} : native;
  always @(posedge clk_i) begin
    if (!reset_n_i || cs_n_i) begin
      cnt <= 4'h0;
      acked <= 1'h0;
      ready <= 1'h0;
    end else if (!acked && cnt < stall_i) cnt <= cnt + 4'h1;
    else begin
      ready <= !acked;
      acked <= 1'h1;
    end
  end
  // polarity; line pulled low when not selected
  assign ack_o = !cs_n_i && (pol ? ready : !ready);
endmodule // lgh_dev_model

// *** lgh_host_port_tb_top.sv ***
// self-checking bench for lgh_host_port with a behavioural device on its pins
// assumes lgh_dev_model and a 200 MHz clock; Wishbone driven by tasks below
`timescale 1ns/1ps
module lgh_host_port_tb_top;
  logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000, rdat;
  logic        ack, hclk, drst_n, endian, pol, bsn, msel, cs_n, wlo_n, whi_n, rlo_n, rhi_n, doe, dack, bi, poe;
  logic [16:0] addr;
  logic [15:0] hdat, ddat, bus_wire, wire_dat, wire_last = 16'h0000;
  logic [3:0]  stall = 4'h0;
  logic        cs_q = 1'h1, bi_seen, rd_split = 1'h0, we_lo_seen, we_hi_seen;
  int          err_total = 0, checks = 0, cyc_cnt = 0, t_go = 0, t_cs = 0, acc_len = 0, falls = 0;
  always #2.5 clk_i = ~clk_i;
  // an undriven wire shows the inverse of its last level, never a lucky match
  assign bus_wire = poe ? hdat : (doe ? ddat : ~wire_last);
  lgh_host_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .host_clock_o(hclk), .dev_reset_n_o(drst_n), .endian_strap_o(endian), .stall_polarity_strap_o(pol),
    .bus_start_n_o(bsn), .host_address_bus_o(addr), .mem_sel_o(msel), .chip_select_n_o(cs_n),
    .low_byte_write_n_o(wlo_n), .high_byte_write_n_o(whi_n), .low_byte_read_n_o(rlo_n),
    .high_byte_read_n_o(rhi_n), .host_data_bus_o(hdat), .host_data_bus_oe_o(poe),
    .host_data_bus_i(bus_wire), .transfer_acknowledge_i(dack), .burst_inhibit_o(bi));
  lgh_dev_model model (.clk_i(hclk), .reset_n_i(drst_n), .endian_i(endian), .polarity_i(pol),
    .addr_i(addr), .mem_sel_i(msel), .cs_n_i(cs_n), .we_lo_n_i(wlo_n), .we_hi_n_i(whi_n),
    .rd_lo_n_i(rlo_n), .bus_i(bus_wire), .stall_i(stall), .dat_o(ddat), .oe_o(doe), .ack_o(dack));
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    cs_q <= cs_n;
    wire_last <= bus_wire;
    if (rlo_n !== rhi_n) rd_split <= 1'h1;
    if (ack && wb_we && wb_adr == 8'h00 && wb_dat[0]) t_go <= cyc_cnt;
    if (cs_q && !cs_n) begin
      t_cs <= cyc_cnt;
      falls <= falls + 1;
      acc_len <= 1;
      bi_seen <= bi;
    end else if (!cs_n) acc_len <= acc_len + 1;
    if (!cs_n) begin
      wire_dat <= bus_wire;
      we_lo_seen <= wlo_n;
      we_hi_seen <= whi_n;
    end
    if (cyc_cnt == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    @(posedge clk_i);
    while (ack !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) err_total++;
    rd = rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wb_w(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_xfer(1'h1, adr, dat, d);
  endtask
  task automatic wb_r(input logic [7:0] adr, output logic [31:0] d);
    wb_xfer(1'h0, adr, 32'h0000_0000, d);
  endtask
  // start one device cycle, optionally poke a second start while busy, wait for done
  task automatic run(input logic [15:0] ctrl, input int s, input int a, input logic poke);
    logic [31:0] st;
    int n;
    n = 0;
    st = 32'h0000_0000;
    wb_w(8'h00, {16'h0000, ctrl});
    if (poke) begin
      wb_r(8'h10, st);
      cmp("busy", 32'h0000_0001, {31'h0, st[0]});
      wb_w(8'h00, {16'h0000, ctrl});
    end
    while (st[1] !== 1'h1 && n < 100) begin
      wb_r(8'h10, st);
      n++;
    end
    cmp("done", 32'h0000_0001, {31'h0, st[1]});
    wb_w(8'h10, 32'h0000_0002);
    if (s >= 0) cmp("setup", s, t_cs - t_go);
    if (a >= 0) cmp("access", a, acc_len);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    wb_r(8'h00, v);
    cmp("ctrl", 32'h0000_8000, v);
    wb_r(8'h08, v);
    cmp("wdata", 32'h0003_0000, v);
    wb_r(8'h0C, v);
    cmp("rdata", 32'h0000_0000, v);
    wb_w(8'h14, 32'hFFFF_FFFF);
    wb_r(8'h14, v);
    cmp("unmapped", 32'h0000_0000, v);
    cmp("pins", 32'h0000_000E, {28'h0, bsn, pol, cs_n, drst_n});
  endtask
  task automatic t_lanes();
    wb_w(8'h00, 32'h0000_0000);
    wb_w(8'h04, 32'h0001_0005);
    wb_w(8'h08, 32'h0003_A55A);
    run(16'h0027, 5, 4, 1'h0);
    cmp("addr", 32'h0001_0005, {15'h0, model.last_addr});
    cmp("memsel", 32'h0000_0001, {31'h0, model.last_mem});
    wb_w(8'h08, 32'h0001_1234);
    run(16'h0027, 1, 4, 1'h0);
    cmp("lo lane", 32'h0000_A534, {16'h0, model.buf_mem[5]});
    wb_w(8'h08, 32'h0002_BEEF);
    run(16'h1007, 2, 4, 1'h0);
    cmp("hi lane", 32'h0000_BE34, {16'h0, model.buf_mem[5]});
  endtask
  task automatic t_timing();
    logic [31:0] v;
    run(16'h2305, 3, 16, 1'h0);
    wb_r(8'h0C, v);
    cmp("read", 32'h0000_BE34, v);
    cmp("rd split", 32'h0000_0000, {31'h0, rd_split});
    wb_w(8'h08, 32'h0003_0F0F);
    run(16'h0157, 5, 6, 1'h0);
    cmp("short write", 32'h0000_0F0F, {16'h0, model.buf_mem[5]});
  endtask
  task automatic t_ack();
    logic [31:0] v;
    stall <= 4'h3;
    wb_w(8'h04, 32'h0000_0007);
    wb_w(8'h08, 32'h0003_C3C3);
    run(16'h4083, -1, -1, 1'h0);
    cmp("stalled", 32'h0000_0001, {31'h0, acc_len > 12});
    cmp("inhibit", 32'h0000_0001, {31'h0, bi_seen});
    run(16'h4081, -1, -1, 1'h0);
    wb_r(8'h0C, v);
    cmp("reg read", 32'h0000_C3C3, v);
    stall <= 4'h0;
  endtask
  task automatic t_busy();
    int n;
    n = falls;
    run(16'h0F07, -1, 64, 1'h1);
    cmp("one cycle", n + 1, falls);
  endtask
  task automatic t_endian();
    logic [31:0] v;
    wb_w(8'h00, 32'h0000_8008);
    wb_w(8'h00, 32'h0000_0008);
    wb_w(8'h04, 32'h0000_0009);
    wb_w(8'h08, 32'h0001_1234);
    run(16'h000F, 1, 4, 1'h0);
    cmp("swapped lanes", 32'h0000_0001, {30'h0, we_hi_seen, we_lo_seen});
    cmp("wire byte", 32'h0000_0034, {24'h0, wire_dat[15:8]});
    run(16'h000D, 1, 4, 1'h0);
    wb_r(8'h0C, v);
    cmp("big read", 32'h0000_0034, v);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_lanes();
    t_timing();
    t_ack();
    t_busy();
    t_endian();
    give_verdict();
  end
endmodule // lgh_host_port_tb_top
